// file: core/midrange_peripheral_chip_select.sv
// midrange and upper peripheral chip-select decoder with an apb register slave
// How it works
// - upper pins: chip select or address, exclusive
// - upper pins held high after reset
// - aux register access activates address pins
// - one-hot size; block split in four
// - role bit 1 selects, 0 gives a1/a2
// - space bit 1 memory, 0 I/O
// - aux ready bit governs upper selects only
// - aux wait field adds 0-3 waits
// - midrange pins idle until both written
// - midrange decoded from multiplexed address phase
// - base field gives address 19:13
// - midrange ready bit governs midrange selects
// - midrange wait field adds 0-3 waits
// - registers undefined until written
//
// The APB slave port was left to the implementer.
`include "chip_select_cfg.svh"
module midrange_peripheral_chip_select
	import chip_select_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [31:0] prdata,
	// processor bus cycle
	input  wire logic        ale,
	input  wire logic [19:0] ad_addr,
	input  wire logic        mem_cycle,
	input  wire logic        cycle_end,
	input  wire logic        ext_ready,
	output logic             cycle_ready,
	// peripheral base from the lower select block
	input  wire logic        periph_base_written,
	input  wire logic [19:0] periph_base,
	// chip-select pins
	output logic       [3:0] midrange_select_pins_n,
	output logic       [1:0] upper_peripheral_select_pins_n
);
	reg16_t      midrange_block_base;
	reg16_t      chip_select_aux_config;
	logic        base_written;
	logic        aux_written;
	logic        aux_touched;
	logic [19:0] cyc_addr;
	logic        cyc_mem;
	logic        cyc_live;
	logic [3:0]  mid_sel;
	logic [1:0]  upper_sel;
	logic [1:0]  addr_bits;
	wait_if      wq ();

	// apb decode
	wire         apb_access = psel && penable;
	wire         apb_write  = apb_access && pwrite;
	wire         hit_base   = (paddr == `MID_BASE_ADDR);
	wire         hit_aux    = (paddr == `AUX_CFG_ADDR);
	wire         hit_status = (paddr == `STATUS_ADDR);
	wire         hit_any    = hit_base || hit_aux || hit_status;

	assign pready  = 1'b1;
	assign pslverr = apb_access && !hit_any;

	// field views
	wire [6:0]   size_field  = chip_select_aux_config[`SIZE_MSB:`SIZE_LSB];
	wire         pin_role    = chip_select_aux_config[`ROLE_BIT];
	wire         space_sel   = chip_select_aux_config[`SPACE_BIT];
	wire         aux_rdy     = chip_select_aux_config[`READY_BIT];
	wire [1:0]   aux_wait    = chip_select_aux_config[`WAIT_MSB:0];
	wire [6:0]   base_field  = midrange_block_base[`BASE_MSB:`BASE_LSB];
	wire         mid_rdy     = midrange_block_base[`READY_BIT];
	wire [1:0]   mid_wait    = midrange_block_base[`WAIT_MSB:0];

	// size in address bits 19:13 as a mask of the bits inside the block
	function automatic logic [6:0] block_mask(input logic [6:0] onehot);
		logic [6:0] m;
		m = 7'h00;
		for (int i = 0; i < 7; i++)
			if (onehot[i])
				m = 7'((8'h01 << i) - 8'h01);
		return m;
	endfunction

	// which quarter of the block an address lands in
	function automatic logic [1:0] quarter(input logic [6:0] onehot,
		input logic [19:0] a);
		logic [1:0] q;
		q = 2'h0;
		for (int i = 0; i < 7; i++)
			if (onehot[i])
				q = a[12 + i -: 2];
		return q;
	endfunction

	// same 256-byte window compare for both upper selects
	function automatic logic periph_hit(input logic [19:0] a,
		input logic [19:0] b);
		return a[19:`PERIPH_SPAN_LOG2] == b[19:`PERIPH_SPAN_LOG2];
	endfunction

	wire [6:0]   size_mask = block_mask(size_field);
	wire         size_ok   = (size_field != 7'h00);
	// base bits 12:0 read as zero, so only bits 19:13 are compared
	wire         mid_hit   = size_ok && ((cyc_addr[19:13] & ~size_mask)
		== (base_field & ~size_mask));
	wire [1:0]   mid_q     = quarter(size_field, cyc_addr);
	wire         mid_en    = base_written && aux_written;
	wire         mid_any   = cyc_live && cyc_mem && mid_en && mid_hit;

	// upper peripheral selects at base plus 1280 and 1536
	wire [19:0]  p5_base   = periph_base + `PERIPH5_OFS;
	wire [19:0]  p6_base   = periph_base + `PERIPH6_OFS;
	wire         space_ok  = (cyc_mem == space_sel);
	wire         p5_hit    = periph_hit(cyc_addr, p5_base);
	wire         p6_hit    = periph_hit(cyc_addr, p6_base);
	wire         up_en     = aux_written && periph_base_written && pin_role;
	wire         up_live   = cyc_live && up_en && space_ok;
	wire [1:0]   up_hit    = up_live ? {p6_hit, p5_hit} : 2'h0;

	// register writes; reserved bits stored as written
	always_ff @(posedge sys_clk) begin
		if (apb_write && hit_base)
			midrange_block_base <= pwdata[15:0];
		if (apb_write && hit_aux)
			chip_select_aux_config <= pwdata[15:0];
	end

	// activation flags
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			base_written <= 1'b0;
			aux_written  <= 1'b0;
			aux_touched  <= 1'b0;
		end else begin
			if (apb_write && hit_base)
				base_written <= 1'b1;
			if (apb_write && hit_aux)
				aux_written <= 1'b1;
			if (apb_access && hit_aux)
				aux_touched <= 1'b1;
		end
	end

	// read mux: status shows activation and sequencer state
	wire [15:0]  status_word = {11'h000, wq.busy, wq.done, aux_touched,
		aux_written, base_written};
	wire [15:0]  rd_word = hit_base   ? midrange_block_base :
		hit_aux    ? chip_select_aux_config :
		hit_status ? status_word : 16'h0000;

	always_ff @(posedge sys_clk) begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= {16'h0000, rd_word};
	end

	// address phase latched off the multiplexed bus at ale
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cyc_addr <= 20'h00000;
			cyc_mem  <= 1'b0;
			cyc_live <= 1'b0;
		end else if (ale) begin
			cyc_addr <= ad_addr;
			cyc_mem  <= mem_cycle;
			cyc_live <= 1'b1;
		end else if (cycle_end) begin
			cyc_live <= 1'b0;
		end
	end

	// latched address bits for the address role
	always_ff @(posedge sys_clk) begin
		if (rst)
			addr_bits <= 2'h0;
		else if (ale)
			addr_bits <= {ad_addr[2], ad_addr[1]};
	end

	// one start per cycle, the cycle after the address is latched
	logic start_q;
	always_ff @(posedge sys_clk) begin
		if (rst)
			start_q <= 1'b0;
		else
			start_q <= ale;
	end

	assign wq.start      = start_q && (mid_any || (up_hit != 2'h0));
	// midrange wins if software let the two overlap
	assign wq.count      = mid_any ? mid_wait : aux_wait;
	assign wq.need_ready = mid_any ? !mid_rdy : !aux_rdy;
	assign wq.ext_ready  = ext_ready;
	assign wq.bus_end    = cycle_end;

	wait_sequencer u_wait (
		.sys_clk (sys_clk),
		.rst     (rst),
		.wq      (wq)
	);

	// cycles that hit no select are answered by the wider bus logic
	assign cycle_ready = wq.done;

	// select pin registers, active low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mid_sel   <= 4'h0;
			upper_sel <= 2'h0;
		end else begin
			for (int i = 0; i < 4; i++)
				mid_sel[i] <= mid_any && (mid_q == 2'(i));
			upper_sel <= up_hit;
		end
	end

	assign midrange_select_pins_n = ~mid_sel;

	// the role bit steers the pins to one use only
	assign upper_peripheral_select_pins_n =
		!aux_touched ? `UPPER_PIN_IDLE :
		(pin_role ? ~upper_sel : addr_bits);

	a_mid_idle_reset: assert property (@(posedge sys_clk)
		disable iff (rst)
		!(base_written && aux_written) |-> midrange_select_pins_n == 4'hf)
		else $error("midrange select before both registers written");
	a_upper_idle: assert property (@(posedge sys_clk)
		disable iff (rst)
		!aux_touched |-> upper_peripheral_select_pins_n == 2'h3)
		else $error("upper pins active before configuration");
	a_pins_reset: assert property (@(posedge sys_clk)
		disable iff (rst)
		$past(rst) |-> (midrange_select_pins_n == `MID_PIN_IDLE
		&& upper_peripheral_select_pins_n == `UPPER_PIN_IDLE))
		else $error("select pins not idle after reset");
	// checked against the bus address itself, not the latch behind the pins
	a_addr_role: assert property (@(posedge sys_clk)
		disable iff (rst)
		(aux_touched && !pin_role && $past(ale)) |->
		upper_peripheral_select_pins_n == $past(ad_addr[2:1]))
		else $error("address role does not carry a1 and a2");
	a_mid_onehot: assert property (@(posedge sys_clk)
		disable iff (rst)
		$countones(~midrange_select_pins_n) <= 1)
		else $error("more than one midrange select active");
	a_mid_from_ale: assert property (@(posedge sys_clk)
		disable iff (rst)
		$fell(midrange_select_pins_n[0]) |-> $past(cyc_live))
		else $error("midrange select without latched address");
	a_mid_release: assert property (@(posedge sys_clk)
		disable iff (rst)
		(cycle_end && !ale) |=> ##1 midrange_select_pins_n == `MID_PIN_IDLE)
		else $error("midrange select outlived its bus cycle");
	a_space_match: assert property (@(posedge sys_clk)
		disable iff (rst)
		(upper_sel != 2'h0) |-> $past(cyc_mem) == space_sel)
		else $error("upper select in wrong bus space");
	a_aux_touch: assert property (@(posedge sys_clk)
		disable iff (rst)
		(apb_access && hit_aux) |=> aux_touched)
		else $error("aux access did not activate pins");
	a_role_excl: assert property (@(posedge sys_clk)
		disable iff (rst)
		(aux_touched && pin_role) |->
		upper_peripheral_select_pins_n != 2'h0)
		else $error("both upper selects active at once");
	a_base_lands: assert property (@(posedge sys_clk)
		disable iff (rst)
		(apb_write && hit_base) |=>
		midrange_block_base == $past(pwdata[15:0]))
		else $error("base register write lost");
	a_aux_lands: assert property (@(posedge sys_clk)
		disable iff (rst)
		(apb_write && hit_aux) |=>
		chip_select_aux_config == $past(pwdata[15:0]))
		else $error("aux register write lost");
	a_upper_waits: assert property (@(posedge sys_clk)
		disable iff (rst)
		(wq.start && !wq.busy && !mid_any && aux_rdy
		&& aux_wait == 2'h3) |-> ##1 !wq.done [*3] ##1 wq.done)
		else $error("upper wait states not inserted as programmed");
	a_mid_no_wait: assert property (@(posedge sys_clk)
		disable iff (rst)
		(wq.start && !wq.busy && mid_any && mid_rdy
		&& mid_wait == 2'h0) |=> wq.done)
		else $error("zero-wait midrange cycle not answered at once");
	a_mid_need_ready: assert property (@(posedge sys_clk)
		disable iff (rst)
		(wq.start && !wq.busy && mid_any && !mid_rdy) |=> !wq.done)
		else $error("midrange cycle ended without external ready");
	a_ready_stands: assert property (@(posedge sys_clk)
		disable iff (rst)
		(cycle_ready && !cycle_end) |=> cycle_ready)
		else $error("cycle ready dropped before the cycle ended");

	c_mid_select: cover property (@(posedge sys_clk) disable iff (rst)
		midrange_select_pins_n[3] == 1'b0);
	c_upper_select: cover property (@(posedge sys_clk) disable iff (rst)
		aux_touched && pin_role && upper_sel != 2'h0);
	c_ready_wait: cover property (@(posedge sys_clk) disable iff (rst)
		wq.busy && !wq.done && ext_ready);
	c_addr_role: cover property (@(posedge sys_clk) disable iff (rst)
		aux_touched && !pin_role && ale);
	c_io_upper: cover property (@(posedge sys_clk) disable iff (rst)
		upper_sel != 2'h0 && !space_sel);
endmodule

// file: include/chip_select_cfg.svh
// register offsets, field positions and reset values for the chip-select block
`ifndef CHIP_SELECT_CFG_SVH
`define CHIP_SELECT_CFG_SVH

`define MID_BASE_OFFSET   12'h0a6
`define AUX_CFG_OFFSET    12'h0a8
`define PERIPH_OFFSET     12'h0a4
`define STATUS_OFFSET     12'h0ac
// byte addresses on the word bus: four times each register index
`define MID_BASE_ADDR     12'h298
`define AUX_CFG_ADDR      12'h2a0
`define STATUS_ADDR       12'h2b0
`define SIZE_MSB          14
`define SIZE_LSB          8
`define ROLE_BIT          7
`define SPACE_BIT         6
`define READY_BIT         2
`define WAIT_MSB          1
`define BASE_MSB          15
`define BASE_LSB          9
`define PERIPH_BASE_MSB   15
`define PERIPH_BASE_LSB   7
`define MID_BASE_RSVD     16'h01f8
`define AUX_CFG_RSVD      16'h8038
`define UPPER_PIN_IDLE    2'h3
`define MID_PIN_IDLE      4'hf
`define PERIPH5_OFS       20'h00500
`define PERIPH6_OFS       20'h00600
`define PERIPH_SPAN_LOG2  8

`endif

// file: include/chip_select_pkg.sv
// types shared by the chip-select block
package chip_select_pkg;
	typedef enum logic [1:0] {
		CYC_IDLE  = 2'b00,
		CYC_WAIT  = 2'b01,
		CYC_READY = 2'b10,
		CYC_DONE  = 2'b11
	} cycle_state_t;
	typedef logic [15:0] reg16_t;
endpackage

// file: include/wait_if.sv
// request and answer between the decoder and the wait-state sequencer
interface wait_if;
	logic       start;
	logic [1:0] count;
	logic       need_ready;
	logic       ext_ready;
	logic       bus_end;
	logic       done;
	logic       busy;
	modport decoder (output start, count, need_ready, ext_ready, bus_end,
		input done, busy);
	modport sequencer (input start, count, need_ready, ext_ready, bus_end,
		output done, busy);
endinterface

// file: core/wait_sequencer.sv
// wait-state counter and external ready wait for one decoded access
module wait_sequencer
	import chip_select_pkg::*;
(
	// clock and reset
	input wire logic   sys_clk,
	input wire logic   rst,
	// decoder side
	wait_if.sequencer  wq
);
	cycle_state_t state;
	cycle_state_t next_state;
	logic [1:0]   waits;
	logic [1:0]   next_waits;

	always_comb begin
		next_state = state;
		next_waits = waits;
		unique case (state)
			CYC_IDLE: begin
				if (wq.start) begin
					next_waits = wq.count;
					if (wq.count != 2'h0)
						next_state = CYC_WAIT;
					else if (wq.need_ready)
						next_state = CYC_READY;
					else
						next_state = CYC_DONE;
				end
			end
			CYC_WAIT: begin
				next_waits = waits - 2'h1;
				if (waits == 2'h1)
					next_state = wq.need_ready ? CYC_READY : CYC_DONE;
			end
			CYC_READY: begin
				// cycle stretched until the device outside answers
				if (wq.ext_ready)
					next_state = CYC_DONE;
			end
			CYC_DONE: begin
				if (wq.bus_end)
					next_state = CYC_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= CYC_IDLE;
			waits <= 2'h0;
		end else begin
			state <= next_state;
			waits <= next_waits;
		end
	end

	assign wq.done = (state == CYC_DONE);
	assign wq.busy = (state != CYC_IDLE);

	a_wait_count_exact: assert property (@(posedge sys_clk)
		disable iff (rst)
		(state == CYC_IDLE && wq.start && wq.count == 2'h2
		&& !wq.need_ready) |-> ##1 !wq.done ##1 !wq.done ##1 wq.done)
		else $error("wait states not inserted as programmed");
	a_ready_holds: assert property (@(posedge sys_clk)
		disable iff (rst)
		(state == CYC_READY && !wq.ext_ready) |=> !wq.done)
		else $error("cycle ended without external ready");
endmodule

// file: verif/cs_partner.sv
// behavioural memory that answers ready some cycles after it is selected
module cs_partner (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// select pins and answer delay
	input  wire logic [3:0] sel_n,
	input  wire logic [3:0] dly,
	output logic            ext_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	wire        hit;
	assign hit = ~&sel_n;
	always_ff @(posedge sys_clk) begin
		if (rst || !hit)
			cnt <= 4'h0;
		else if (cnt != 4'hf)
			cnt <= cnt + 4'h1;
	end
	// low whenever deselected, so a late ready never leaks into the next cycle
	assign ext_ready = hit && (cnt >= dly);
endmodule

// file: verif/test_midrange_peripheral_chip_select.sv
// self-checking bench for the midrange and upper peripheral chip selects
module test_midrange_peripheral_chip_select;
	timeunit 1ns;
	timeprecision 1ns;
	import chip_select_pkg::*;
	// byte addresses: four times each register index
	localparam logic [11:0] base_a = 12'h298;
	localparam logic [11:0] aux_a  = 12'h2a0;
	localparam logic [11:0] stat_a = 12'h2b0;
	logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, ale = 0, mem_cycle = 0, cycle_end = 0;
	logic        ext_ready, cycle_ready, pbw = 0, er;
	logic [19:0] ad_addr = 0;
	logic [3:0]  mid_n, dly = 0, seen_mid;
	logic [1:0]  up_n, seen_up;
	logic [15:0] bv;
	int          err_total = 0, checked = 0, seed = 32'hf079, n, cyc = 0;
	int          b, sz, a;
	midrange_peripheral_chip_select dut_u (.sys_clk(sys_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .ale(ale), .ad_addr(ad_addr),
		.mem_cycle(mem_cycle), .cycle_end(cycle_end),
		.ext_ready(ext_ready), .cycle_ready(cycle_ready),
		.periph_base_written(pbw), .periph_base(20'h0c000),
		.midrange_select_pins_n(mid_n),
		.upper_peripheral_select_pins_n(up_n));
	cs_partner mem_u (.sys_clk(sys_clk), .rst(rst), .sel_n(mid_n),
		.dly(dly), .ext_ready(ext_ready));
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
	end
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic apb(logic wr, logic [11:0] ad, logic [15:0] d);
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= {16'h0, d};
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// one bus cycle; pins sampled two edges after the ale edge
	task automatic bus(logic [19:0] ad, logic mem);
		@(posedge sys_clk);
		ale <= 1;
		ad_addr <= ad;
		mem_cycle <= mem;
		@(posedge sys_clk);
		ale <= 0;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (n == 2) begin
				seen_mid = mid_n;
				seen_up = up_n;
			end
		end while (cycle_ready !== 1'b1 && n < 40);
		cycle_end <= 1;
		@(posedge sys_clk);
		cycle_end <= 0;
	endtask
	// reserved positions are written as ones
	function automatic logic [15:0] auxv(int s, logic ro, sp, rdy,
		logic [1:0] w);
		return 16'h8038 | (16'h1 << (s + 8)) | {8'h0, ro, sp, 3'h0, rdy, w};
	endfunction
	function automatic logic [15:0] basev(int bs, logic rdy, logic [1:0] w);
		logic [19:0] x;
		x = bs;
		return {x[19:13], 6'h3f, rdy, w};
	endfunction
	function automatic logic [3:0] emid(int ad, bs, s);
		if (ad < bs || ad >= bs + (1 << (13 + s)))
			return 4'hf;
		return ~(4'h1 << ((ad - bs) >> (11 + s)));
	endfunction
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 0;
		chk(mid_n, 4'hf);
		chk(up_n, 2'h3);
		bv = basev(32'h20000, 1, 0);
		apb(1, base_a, bv);
		bus(20'h20000, 1);
		chk(seen_mid, 4'hf);
		chk(seen_up, 2'h3);
		apb(0, base_a, 0);
		chk(rd, {16'h0, bv});
		apb(1, 12'h0b0, 0);
		chk(er, 1);
		$display("test reset and activation done");
		for (sz = 0; sz < 7; sz++) begin
			b = $unsigned($random(seed)) & 32'hfffff & ~((1 << (13 + sz)) - 1);
			if (sz == 6)
				b = 0;
			apb(1, base_a, basev(b, 1, sz % 4));
			apb(1, aux_a, auxv(sz, 1, 1, 1, 0));
			for (int k = 0; k < 4; k++) begin
				a = b + ($unsigned($random(seed)) % (1 << (13 + sz)));
				if (k == 3)
					a = (b + (1 << (13 + sz))) & 32'hfffff;
				bus(a[19:0], 1);
				chk(seen_mid, emid(a, b, sz));
				if (k < 3)
					chk(n, sz % 4 + 2);
			end
		end
		$display("test block sizes and waits done");
		apb(1, base_a, basev(32'h20000, 0, 1));
		apb(1, aux_a, auxv(0, 1, 1, 1, 0));
		apb(0, stat_a, 0);
		chk(rd, 32'h0000_0007);
		chk(er, 0);
		dly <= 4'h6;
		bus(20'h20800, 1);
		chk(seen_mid, 4'hd);
		chk(n > 4 && n < 40, 1);
		dly <= 4'h0;
		$display("test external ready done");
		apb(1, aux_a, auxv(0, 0, 1, 1, 0));
		for (int k = 0; k < 4; k++) begin
			bus(20'h30000 | (k << 1), 1);
			chk(seen_up, k[1:0]);
		end
		pbw <= 1;
		apb(1, aux_a, auxv(0, 1, 1, 1, 2));
		bus(20'h0c500, 1);
		chk(seen_up, 2'b10);
		chk(n, 4);
		bus(20'h0c600, 1);
		chk(seen_up, 2'b01);
		bus(20'h0c500, 0);
		chk(seen_up, 2'b11);
		apb(1, aux_a, auxv(0, 1, 0, 1, 3));
		bus(20'h0c500, 0);
		chk(seen_up, 2'b10);
		chk(n, 5);
		$display("test upper selects done");
		conclude();
	end
endmodule
